// ==== src/gss_defines.svh ====
`ifndef GSS_DEFINES_SVH
`define GSS_DEFINES_SVH
// register indices on the plain register port
`define GSS_ADDR_W 3
`define GSS_DATA_W 16
`define GSS_REG_MODE 3'h0
`define GSS_REG_THRESH 3'h1
`define GSS_REG_HYST 3'h2
`define GSS_REG_RET_DLY 3'h3
`define GSS_REG_BLEND 3'h4
`define GSS_REG_PIP_SEL 3'h5
`define GSS_REG_PIP_LVL 3'h6
`define GSS_REG_STATUS 3'h7
// setting limits
`define GSS_LEVEL_MAX 16'h4e20
`define GSS_TIME_MAX 16'h2710
`define GSS_MODE_MAX 16'h000a
`define GSS_PIP_MAX 16'h0004
// reset values
`define GSS_MODE_RST 4'h0
`define GSS_LEVEL_RST 16'h0000
`define GSS_TIME_RST 16'h0000
`define GSS_PIP_RST 3'h4
// gain switching modes
`define GSS_MODE_FIX1 4'h0
`define GSS_MODE_FIX2 4'h1
`define GSS_MODE_DEV 4'h6
`define GSS_MODE_CMD 4'h7
`define GSS_MODE_NOTDONE 4'h8
`define GSS_MODE_SPEED 4'h9
`define GSS_MODE_CMD_SPEED 4'ha
// speed loop selector values
`define GSS_PIP_TORQUE 3'h0
`define GSS_PIP_SPDCMD 3'h1
`define GSS_PIP_ACCEL 3'h2
`define GSS_PIP_DEV 3'h3
// status field positions
`define GSS_ST_SET2 0
`define GSS_ST_P_ONLY 1
`define GSS_ST_RETURNING 2
`define GSS_ST_WEIGHT_LSB 4
// time base: settings count in 0.1 ms
`define GSS_CLK_PERIOD_NS 5
`define GSS_TIME_UNIT_NS 100000
`define GSS_TICK_CYCLES (`GSS_TIME_UNIT_NS / `GSS_CLK_PERIOD_NS)
// blend weight full scale
`define GSS_WEIGHT_W 11
`define GSS_WEIGHT_FULL 11'h400
`endif

// ==== src/gss_pkg.sv ====
`default_nettype none
package gss_pkg;
  // gain selector states
  typedef enum logic [1:0] {
    GSS_GAIN1,
    GSS_GAIN2,
    GSS_RETURN
  } gss_gain_state_e;
  // control quantity as delivered by the loops
  typedef logic signed [31:0] gss_quantity_t;
endpackage
`default_nettype wire

// ==== src/gss_hyst_cmp.sv ====
`timescale 1ns/1ps
`default_nettype none
module gss_hyst_cmp (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // compared quantity and settings
  input wire gss_pkg::gss_quantity_t value,
  input wire logic [15:0] threshold,
  input wire logic [15:0] hysteresis,
  // result
  output logic above_r
);
  logic [31:0] mag;
  logic [32:0] mag_plus_hyst;

  // magnitude and release sum
  assign mag = value[31] ? 32'(-value) : 32'(value);
  assign mag_plus_hyst = {1'b0, mag} + {17'h0, hysteresis};

  // set above threshold, release below threshold minus hysteresis
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      above_r <= 1'b0;
    end else if (mag > {16'h0000, threshold}) begin
      above_r <= 1'b1;
    end else if (mag_plus_hyst < {17'h0, threshold}) begin
      above_r <= 1'b0;
    end
  end
endmodule // gss_hyst_cmp
`default_nettype wire

// ==== src/gss_blend_ramp.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "gss_defines.svh"
module gss_blend_ramp #(
  parameter int unsigned TICK_CYCLES = `GSS_TICK_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // target set and ramp time in 0.1 ms
  input wire logic to_set2,
  input wire logic [15:0] blend_time,
  // weight of set 2, full scale means set 2 only
  output logic [`GSS_WEIGHT_W-1:0] weight_r
);
  logic [31:0] ramp_cycles;
  logic [31:0] acc_r;
  logic [31:0] acc_nxt;
  logic at_target;

  // ramp length in clock cycles and per-cycle accumulation
  assign ramp_cycles = 32'(blend_time) * 32'(TICK_CYCLES);
  assign acc_nxt = acc_r + 32'(`GSS_WEIGHT_FULL);
  assign at_target = to_set2 ? (weight_r == `GSS_WEIGHT_FULL) : (weight_r == '0);

  // one weight step each time the accumulator passes the ramp length
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      weight_r <= '0;
      acc_r <= '0;
    end else if (at_target) begin
      acc_r <= '0;
    end else if (ramp_cycles == '0) begin
      weight_r <= to_set2 ? `GSS_WEIGHT_FULL : '0;
      acc_r <= '0;
    end else if (acc_nxt >= ramp_cycles) begin
      weight_r <= to_set2 ? weight_r + 1'b1 : weight_r - 1'b1;
      acc_r <= acc_nxt - ramp_cycles;
    end else begin
      acc_r <= acc_nxt;
    end
  end
endmodule // gss_blend_ramp
`default_nettype wire

// ==== src/gss_gain_selector.sv ====
// Overview of operation
// - deviation mode: set 2 above threshold, set 1 after delay below it
// - mode 7: set 2 while position command present, set 1 after delay
// - mode 8: set 2 while positioning incomplete, set 1 after delay
// - mode 9: set 2 above speed threshold, set 1 after delay below it
// - mode 10: set 2 on command; return needs no command, low speed, delay
// - switching threshold settable 0 to 20000 in quantity counts
// - hysteresis settable 0 to 20000, same scaling, used in judging
// - return to set 1 waits settable 0 to 1000.0 ms after release
// - position gain moves between sets over settable 0 to 1000.0 ms
// - speed loop selector 0 to 4 picks the PI or P condition
// - selector 0: P only when torque command above switch level
// - selector 1: P only when speed command above switch level
// - selector 2: P only when acceleration above switch level
// - selector 3: P only when position deviation above switch level
// - selector 4: speed loop always PI
// - switch level uses same counts as the gain threshold
`timescale 1ns/1ps
`default_nettype none
`include "gss_defines.svh"
module gss_gain_selector #(
  parameter int unsigned TICK_CYCLES = `GSS_TICK_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic [`GSS_ADDR_W-1:0] reg_addr,
  input wire logic [`GSS_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`GSS_DATA_W-1:0] reg_rdata_r,
  // control quantities from the loops
  input wire gss_pkg::gss_quantity_t torque_cmd,
  input wire gss_pkg::gss_quantity_t speed_cmd,
  input wire gss_pkg::gss_quantity_t accel,
  input wire gss_pkg::gss_quantity_t pos_dev,
  input wire gss_pkg::gss_quantity_t actual_speed,
  input wire logic pos_cmd_active,
  input wire logic positioning_done,
  // decisions
  output logic gain_set2_r,
  output logic [`GSS_WEIGHT_W-1:0] pos_gain_weight_r,
  output logic speed_p_only_r
);
  // settings
  logic [3:0] gain_switch_mode_sel_r;
  logic [15:0] gain_switch_threshold_r;
  logic [15:0] gain_switch_hysteresis_r;
  logic [15:0] gain_return_delay_r;
  logic [15:0] position_gain_blend_time_r;
  logic [2:0] speed_loop_pi_p_selector_r;
  logic [15:0] speed_loop_switch_level_r;

  // gain selector state
  gss_pkg::gss_gain_state_e gain_state_r;
  gss_pkg::gss_gain_state_e gain_state_nxt;
  logic [31:0] tick_cnt_r;
  logic [15:0] dly_cnt_r;
  logic tick;
  logic dly_done;
  logic dev_above;
  logic spd_above;
  logic trig_hold;
  logic trig_set;
  logic [`GSS_WEIGHT_W-1:0] weight;
  logic p_only_nxt;
  logic [15:0] status;

  // clip a written value into its range
  function automatic logic [15:0] sat(input logic [15:0] v, input logic [15:0] max);
    sat = (v > max) ? max : v;
  endfunction

  // magnitude of a loop quantity above a level
  function automatic logic above(input gss_pkg::gss_quantity_t v, input logic [15:0] lvl);
    logic [31:0] m;
    m = v[31] ? 32'(-v) : 32'(v);
    above = m > {16'h0000, lvl};
  endfunction

  // settings writes, clipped to their ranges
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_switch_mode_sel_r <= `GSS_MODE_RST;
      gain_switch_threshold_r <= `GSS_LEVEL_RST;
      gain_switch_hysteresis_r <= `GSS_LEVEL_RST;
      gain_return_delay_r <= `GSS_TIME_RST;
      position_gain_blend_time_r <= `GSS_TIME_RST;
      speed_loop_pi_p_selector_r <= `GSS_PIP_RST;
      speed_loop_switch_level_r <= `GSS_LEVEL_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `GSS_REG_MODE: begin
          gain_switch_mode_sel_r <= 4'(sat(reg_wdata, `GSS_MODE_MAX));
        end
        `GSS_REG_THRESH: begin
          gain_switch_threshold_r <= sat(reg_wdata, `GSS_LEVEL_MAX);
        end
        `GSS_REG_HYST: begin
          gain_switch_hysteresis_r <= sat(reg_wdata, `GSS_LEVEL_MAX);
        end
        `GSS_REG_RET_DLY: begin
          gain_return_delay_r <= sat(reg_wdata, `GSS_TIME_MAX);
        end
        `GSS_REG_BLEND: begin
          position_gain_blend_time_r <= sat(reg_wdata, `GSS_TIME_MAX);
        end
        `GSS_REG_PIP_SEL: begin
          speed_loop_pi_p_selector_r <= 3'(sat(reg_wdata, `GSS_PIP_MAX));
        end
        `GSS_REG_PIP_LVL: begin
          speed_loop_switch_level_r <= sat(reg_wdata, `GSS_LEVEL_MAX);
        end
        default: begin
        end
      endcase
    end
  end

  // status word
  always_comb begin
    status = '0;
    status[`GSS_ST_SET2] = gain_set2_r;
    status[`GSS_ST_P_ONLY] = speed_p_only_r;
    status[`GSS_ST_RETURNING] = (gain_state_r == gss_pkg::GSS_RETURN);
    status[`GSS_ST_WEIGHT_LSB +: `GSS_WEIGHT_W] = pos_gain_weight_r;
  end

  // read data valid only in the cycle after the read strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_r <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `GSS_REG_MODE: reg_rdata_r <= {12'h000, gain_switch_mode_sel_r};
        `GSS_REG_THRESH: reg_rdata_r <= gain_switch_threshold_r;
        `GSS_REG_HYST: reg_rdata_r <= gain_switch_hysteresis_r;
        `GSS_REG_RET_DLY: reg_rdata_r <= gain_return_delay_r;
        `GSS_REG_BLEND: reg_rdata_r <= position_gain_blend_time_r;
        `GSS_REG_PIP_SEL: reg_rdata_r <= {13'h0, speed_loop_pi_p_selector_r};
        `GSS_REG_PIP_LVL: reg_rdata_r <= speed_loop_switch_level_r;
        `GSS_REG_STATUS: reg_rdata_r <= status;
      endcase
    end else begin
      reg_rdata_r <= '0;
    end
  end

  // deviation comparator with hysteresis
  gss_hyst_cmp u_dev_cmp (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .value(pos_dev),
    .threshold(gain_switch_threshold_r),
    .hysteresis(gain_switch_hysteresis_r),
    .above_r(dev_above)
  );

  // actual speed comparator with hysteresis
  gss_hyst_cmp u_spd_cmp (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .value(actual_speed),
    .threshold(gain_switch_threshold_r),
    .hysteresis(gain_switch_hysteresis_r),
    .above_r(spd_above)
  );

  // conditions that enter and hold the second gain set
  // mode 10 enters on a command only, speed merely delays the return
  always_comb begin
    trig_set = 1'b0;
    trig_hold = 1'b0;
    unique case (gain_switch_mode_sel_r)
      `GSS_MODE_DEV: begin
        trig_set = dev_above;
        trig_hold = dev_above;
      end
      `GSS_MODE_CMD: begin
        trig_set = pos_cmd_active;
        trig_hold = pos_cmd_active;
      end
      `GSS_MODE_NOTDONE: begin
        trig_set = !positioning_done;
        trig_hold = !positioning_done;
      end
      `GSS_MODE_SPEED: begin
        trig_set = spd_above;
        trig_hold = spd_above;
      end
      `GSS_MODE_CMD_SPEED: begin
        trig_set = pos_cmd_active;
        trig_hold = pos_cmd_active || spd_above;
      end
      default: begin
        trig_set = 1'b0;
        trig_hold = 1'b0;
      end
    endcase
  end

  // 0.1 ms time base, restarted when the return delay starts
  assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= '0;
    end else if (gain_state_r != gss_pkg::GSS_RETURN || tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end

  // elapsed return delay in 0.1 ms
  assign dly_done = (dly_cnt_r >= gain_return_delay_r);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dly_cnt_r <= '0;
    end else if (gain_state_r != gss_pkg::GSS_RETURN) begin
      dly_cnt_r <= '0;
    end else if (tick && !dly_done) begin
      dly_cnt_r <= dly_cnt_r + 16'h0001;
    end
  end

  // gain set state machine
  always_comb begin
    gain_state_nxt = gain_state_r;
    if (gain_switch_mode_sel_r == `GSS_MODE_FIX1) begin
      gain_state_nxt = gss_pkg::GSS_GAIN1;
    end else if (gain_switch_mode_sel_r == `GSS_MODE_FIX2) begin
      gain_state_nxt = gss_pkg::GSS_GAIN2;
    end else begin
      unique case (gain_state_r)
        gss_pkg::GSS_GAIN1: begin
          if (trig_set) begin
            gain_state_nxt = gss_pkg::GSS_GAIN2;
          end
        end
        gss_pkg::GSS_GAIN2: begin
          if (!trig_hold) begin
            gain_state_nxt = (gain_return_delay_r == '0) ? gss_pkg::GSS_GAIN1 :
                             gss_pkg::GSS_RETURN;
          end
        end
        gss_pkg::GSS_RETURN: begin
          if (trig_hold) begin
            gain_state_nxt = gss_pkg::GSS_GAIN2;
          end else if (dly_done) begin
            gain_state_nxt = gss_pkg::GSS_GAIN1;
          end
        end
        default: begin
          gain_state_nxt = gss_pkg::GSS_GAIN1;
        end
      endcase
    end
  end

  // state and gain select output
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_state_r <= gss_pkg::GSS_GAIN1;
      gain_set2_r <= 1'b0;
    end else begin
      gain_state_r <= gain_state_nxt;
      gain_set2_r <= (gain_state_nxt != gss_pkg::GSS_GAIN1);
    end
  end

  // smooth position gain changeover
  gss_blend_ramp #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_blend (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .to_set2(gain_set2_r),
    .blend_time(position_gain_blend_time_r),
    .weight_r(weight)
  );

  // registered copy of the blend weight for the output
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_gain_weight_r <= '0;
    end else begin
      pos_gain_weight_r <= weight;
    end
  end

  // speed loop PI or P decision
  always_comb begin
    unique case (speed_loop_pi_p_selector_r)
      `GSS_PIP_TORQUE: p_only_nxt = above(torque_cmd, speed_loop_switch_level_r);
      `GSS_PIP_SPDCMD: p_only_nxt = above(speed_cmd, speed_loop_switch_level_r);
      `GSS_PIP_ACCEL: p_only_nxt = above(accel, speed_loop_switch_level_r);
      `GSS_PIP_DEV: p_only_nxt = above(pos_dev, speed_loop_switch_level_r);
      default: p_only_nxt = 1'b0;
    endcase
  end

  // registered speed loop mode, high means P only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      speed_p_only_r <= 1'b0;
    end else begin
      speed_p_only_r <= p_only_nxt;
    end
  end
endmodule // gss_gain_selector
`default_nettype wire

// ==== verif/gss_gain_selector_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module gss_gain_selector_props #(
  parameter int unsigned TICK_CYCLES = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata_r,
  // loop quantities
  input wire gss_pkg::gss_quantity_t torque_cmd,
  input wire gss_pkg::gss_quantity_t speed_cmd,
  input wire gss_pkg::gss_quantity_t accel,
  input wire gss_pkg::gss_quantity_t pos_dev,
  input wire gss_pkg::gss_quantity_t actual_speed,
  input wire logic pos_cmd_active,
  input wire logic positioning_done,
  // decisions
  input wire logic gain_set2_r,
  input wire logic [10:0] pos_gain_weight_r,
  input wire logic speed_p_only_r
);
  logic [3:0] mode_q;
  logic [2:0] sel_q;
  logic [15:0] thr_q, dly_q, bl_q, lvl_q;
  logic [31:0] pip_q;
  function automatic logic [31:0] mag(input gss_pkg::gss_quantity_t v);
    return v[31] ? 32'(-v) : 32'(v);
  endfunction
  function automatic logic [15:0] clip(input logic [15:0] v, input logic [15:0] m);
    return (v > m) ? m : v;
  endfunction
  // shadow of the written settings except the hysteresis
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= 4'h0;
      sel_q <= 3'h4;
      thr_q <= 16'h0;
      dly_q <= 16'h0;
      bl_q <= 16'h0;
      lvl_q <= 16'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        3'h0: mode_q <= 4'(clip(reg_wdata, 16'h000a));
        3'h1: thr_q <= clip(reg_wdata, 16'h4e20);
        3'h3: dly_q <= clip(reg_wdata, 16'h2710);
        3'h4: bl_q <= clip(reg_wdata, 16'h2710);
        3'h5: sel_q <= 3'(clip(reg_wdata, 16'h0004));
        3'h6: lvl_q <= clip(reg_wdata, 16'h4e20);
        default: ;
      endcase
    end
  end
  // quantity picked by the speed loop selector
  always_comb begin
    case (sel_q)
      3'h0: pip_q = mag(torque_cmd);
      3'h1: pip_q = mag(speed_cmd);
      3'h2: pip_q = mag(accel);
      3'h3: pip_q = mag(pos_dev);
      default: pip_q = 32'h0;
    endcase
  end
  wire logic p_want = (sel_q < 3'h4) && (pip_q > {16'h0, lvl_q});
  wire logic dev_hi = mag(pos_dev) > {16'h0, thr_q};
  wire logic spd_hi = mag(actual_speed) > {16'h0, thr_q};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // command released with one delay unit
  sequence s_release;
    mode_q == 4'h7 && dly_q == 16'h1 && TICK_CYCLES == 4 && gain_set2_r && $fell(pos_cmd_active);
  endsequence
  sequence s_hold_drop;
    gain_set2_r [*5] ##[1:3] !gain_set2_r;
  endsequence
  a_cmd_two: assert property (mode_q == 4'h7 && pos_cmd_active |=> gain_set2_r)
    else $error("set 2 missing on command");
  a_open_two: assert property (mode_q == 4'h8 && !positioning_done |=> gain_set2_r)
    else $error("set 2 missing while not positioned");
  a_dev_two: assert property ((mode_q == 4'h6 && dev_hi) [*2] |-> ##[1:2] gain_set2_r)
    else $error("set 2 missing on deviation");
  a_spd_two: assert property ((mode_q == 4'h9 && spd_hi) [*2] |-> ##[1:2] gain_set2_r)
    else $error("set 2 missing on speed");
  a_cmdspd_two: assert property (mode_q == 4'ha && pos_cmd_active |=> gain_set2_r)
    else $error("set 2 missing on command with speed");
  a_cmdspd_entry: assert property (mode_q == 4'ha && !gain_set2_r && !pos_cmd_active |=>
    !gain_set2_r)
    else $error("set 2 entered without command");
  a_ret_delay: assert property (s_release |-> s_hold_drop)
    else $error("return delay length wrong");
  a_pip_follow: assert property (speed_p_only_r == $past(p_want))
    else $error("speed loop mode wrong");
  a_pip_off: assert property (sel_q == 3'h4 && $past(sel_q) == 3'h4 |-> !speed_p_only_r)
    else $error("p only with selector 4");
  a_wt_full: assert property ((bl_q == 16'h0 && gain_set2_r) [*3] |->
    pos_gain_weight_r == 11'h400)
    else $error("weight not full");
endmodule // gss_gain_selector_props
`default_nettype wire

// ==== verif/gss_gain_selector_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module gss_gain_selector_tb_top;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic pos_cmd_active = 1'b0;
  logic positioning_done = 1'b1;
  gss_pkg::gss_quantity_t q [5] = '{default: '0};
  logic [15:0] reg_rdata_r, d;
  logic [10:0] pos_gain_weight_r;
  logic gain_set2_r, speed_p_only_r;
  int bad_count = 0;
  int n_compared = 0;
  int regs [8] = '{0, 0, 0, 0, 0, 4, 0, 0};
  int lv;
  logic exp_p;
  // design with a short time tick
  gss_gain_selector #(.TICK_CYCLES(4)) u_gss_gain_selector (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .torque_cmd(q[0]),
    .speed_cmd(q[1]), .accel(q[2]), .pos_dev(q[3]), .actual_speed(q[4]),
    .pos_cmd_active(pos_cmd_active), .positioning_done(positioning_done),
    .gain_set2_r(gain_set2_r), .pos_gain_weight_r(pos_gain_weight_r),
    .speed_p_only_r(speed_p_only_r));
  // clock
  always #2.5 core_clk = ~core_clk;
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp({15'h0, got}, {15'h0, exp});
  endtask
  function automatic int lim(input int a);
    case (a)
      0: return 10;
      3, 4: return 10000;
      5: return 4;
      default: return 20000;
    endcase
  endfunction
  task automatic wr(input int a, input int v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= 3'(a);
    reg_wdata <= 16'(v);
    @(posedge core_clk);
    reg_wr <= 1'b0;
    if (a < 7) regs[a] = (v > lim(a)) ? lim(a) : v;
  endtask
  task automatic rd(input int a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= 3'(a);
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_r;
  endtask
  task automatic at(input int n, input logic exp);
    repeat (n) @(posedge core_clk);
    #1 cmp_bit(gain_set2_r, exp);
  endtask
  // still set 2 inside the delay, set 1 after it
  task automatic fall_chk;
    at(4, 1'b1);
    at(8, 1'b0);
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #100us;
    bad_count++;
    print_verdict;
  end
  // main sequence
  initial begin
    void'($urandom(96662));
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    wr(7, 16'hffff);
    for (int a = 0; a < 8; a++) begin
      rd(a);
      cmp(d, 16'(regs[a]));
    end
    for (int a = 0; a < 7; a++) begin
      wr(a, $urandom_range(65535));
      rd(a);
      cmp(d, 16'(regs[a]));
      wr(a, $urandom_range(lim(a)));
      rd(a);
      cmp(d, 16'(regs[a]));
    end
    wr(4, 0);
    wr(3, 0);
    wr(5, 4);
    wr(0, 0);
    // position command, no delay then one unit
    wr(0, 7);
    @(posedge core_clk) pos_cmd_active <= 1'b1;
    at(2, 1'b1);
    @(posedge core_clk) pos_cmd_active <= 1'b0;
    at(3, 1'b0);
    wr(3, 1);
    @(posedge core_clk) pos_cmd_active <= 1'b1;
    at(2, 1'b1);
    @(posedge core_clk) pos_cmd_active <= 1'b0;
    fall_chk;
    // retrigger while the delay runs
    wr(3, 2);
    @(posedge core_clk) pos_cmd_active <= 1'b1;
    at(2, 1'b1);
    @(posedge core_clk) pos_cmd_active <= 1'b0;
    repeat (3) @(posedge core_clk);
    pos_cmd_active <= 1'b1;
    @(posedge core_clk) pos_cmd_active <= 1'b0;
    at(8, 1'b1);
    at(8, 1'b0);
    wr(3, 1);
    // positioning not complete
    wr(0, 8);
    @(posedge core_clk) positioning_done <= 1'b0;
    at(2, 1'b1);
    @(posedge core_clk) positioning_done <= 1'b1;
    fall_chk;
    // deviation with threshold and hysteresis
    wr(1, 1000);
    wr(2, 100);
    wr(0, 6);
    @(posedge core_clk) q[3] <= 1000;
    at(4, 1'b0);
    @(posedge core_clk) q[3] <= -1001;
    at(3, 1'b1);
    @(posedge core_clk) q[3] <= 950;
    at(20, 1'b1);
    @(posedge core_clk) q[3] <= 850;
    fall_chk;
    // actual speed, deviation ignored
    wr(0, 9);
    @(posedge core_clk) q[3] <= 30000;
    at(4, 1'b0);
    @(posedge core_clk) q[4] <= 2000;
    at(3, 1'b1);
    @(posedge core_clk) q[4] <= 0;
    fall_chk;
    // command plus speed
    wr(0, 10);
    @(posedge core_clk) pos_cmd_active <= 1'b1;
    at(2, 1'b1);
    @(posedge core_clk) q[4] <= 2000;
    @(posedge core_clk) pos_cmd_active <= 1'b0;
    at(12, 1'b1);
    rd(7);
    cmp(d, 16'h4001);
    @(posedge core_clk) q[4] <= 0;
    fall_chk;
    // speed alone must not enter set 2 in mode 10
    @(posedge core_clk) q[4] <= 2000;
    at(6, 1'b0);
    @(posedge core_clk) q[4] <= 0;
    // gradual position gain ramp, 400 units of 4 cycles is 1600 cycles
    wr(4, 400);
    wr(0, 1);
    repeat (8) @(posedge core_clk);
    #1 cmp_bit(pos_gain_weight_r > 11'h0 && pos_gain_weight_r < 11'h400, 1'b1);
    repeat (800) @(posedge core_clk);
    #1 cmp_bit(pos_gain_weight_r > 11'h1c0 && pos_gain_weight_r < 11'h240, 1'b1);
    repeat (820) @(posedge core_clk);
    #1 cmp(16'(pos_gain_weight_r), 16'h0400);
    // speed loop selector, every value
    for (int s = 0; s < 5; s++) begin
      lv = $urandom_range(20000);
      wr(5, s);
      wr(6, lv);
      for (int i = 0; i < 6; i++) begin
        @(posedge core_clk);
        for (int k = 0; k < 4; k++)
          q[k] <= (k == s && i < 2) ? ((i == 0) ? lv : -lv - 1) : $urandom_range(40000) - 20000;
        @(posedge core_clk);
        #1 exp_p = s < 4 && (q[s] < 0 ? -q[s] : q[s]) > lv;
        cmp_bit(speed_p_only_r, exp_p);
      end
    end
    print_verdict;
  end
endmodule // gss_gain_selector_tb_top
bind gss_gain_selector gss_gain_selector_props #(.TICK_CYCLES(TICK_CYCLES))
  u_gss_gain_selector_props (
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .torque_cmd(torque_cmd),
  .speed_cmd(speed_cmd), .accel(accel), .pos_dev(pos_dev), .actual_speed(actual_speed),
  .pos_cmd_active(pos_cmd_active), .positioning_done(positioning_done),
  .gain_set2_r(gain_set2_r), .pos_gain_weight_r(pos_gain_weight_r),
  .speed_p_only_r(speed_p_only_r));
`default_nettype wire
